/* core/dccd_consts.svh */
// Function
// [RULE_01] Every host port moves data as single bytes, one after another.
// [RULE_02] A write frame is one address byte plus that register's data bytes.
// [RULE_03] Host sends exactly the defined byte count; wrong counts desync the decoder.
// [RULE_04] One register map and frame format on all four host ports.
// [RULE_05] Configuration registers only set state; queries would return data.
// [RULE_06] Address 0x10 takes 48-bit word plus direct first oscillator flag.
// [RULE_07] After each write on PXIe or RS232 the device returns one byte.
// [RULE_08] State reload: bit 0 clear reprograms current state, set restores defaults.
// [RULE_09] Any configuration write applies without a prior state reload.
// [RULE_10] External locking starts only once a reference is detected.
// [RULE_11] Without external reference, secondary oscillator locks to base oscillator.
// [RULE_12] With external reference active, both oscillators lock to it.
// [RULE_13] Base oscillator stays powered while external reference is selected.
// [RULE_14] Reference output, when enabled, gives 10 MHz or 100 MHz by select.
// [RULE_15] Base oscillator tuned by a 14-bit DAC word, rewritable anytime.
// [RULE_16] Internal first oscillator equals input plus first IF, 1 Hz resolution.
// [RULE_17] Externally routed first oscillator takes the written value directly.
// [RULE_18] Second oscillator is IF1 minus IF2, 5 MHz steps, 6.25 to 6.45 GHz.
// [RULE_19] Third oscillator from IF2 and IF3, ranges depend on spectral inversion.
// [RULE_20] Plan parameter: 48-bit word plus 4-bit selector in final byte.
// [RULE_21] Multi-byte data arrives least significant byte first.
// [RULE_22] Unused data bits are ignored when decoding.
// [RULE_23] Address picks length; bytes are counted; update applies after last byte.
`ifndef DCCD_CONSTS_SVH
`define DCCD_CONSTS_SVH

`define DCCD_A_RELOAD   8'h01
`define DCCD_A_ACTIVE   8'h02
`define DCCD_A_SYNTH    8'h03
`define DCCD_A_INWORD   8'h10
`define DCCD_A_OUTWORD  8'h11
`define DCCD_A_PREAMP   8'h14
`define DCCD_A_ATTEN    8'h15
`define DCCD_A_ROUTE    8'h16
`define DCCD_A_AUTOG    8'h17
`define DCCD_A_SAVE     8'h18
`define DCCD_A_PWRDN    8'h19
`define DCCD_A_TBSEL    8'h1a
`define DCCD_A_TBTRIM   8'h1b
`define DCCD_A_LO1RT    8'h1c
`define DCCD_A_CAL      8'h1d
`define DCCD_A_NVM      8'h1e
`define DCCD_A_PLAN     8'h1f

`define DCCD_ACK_BYTE   8'h00
`define DCCD_LOOPG_RST  2'h1
`define DCCD_IF1_RST    48'd7500000000
`define DCCD_IF2_RST    48'd1250000000
`define DCCD_IF3_RST    48'd0
`define DCCD_SEL_IF1    4'h0
`define DCCD_SEL_IF2    4'h1
`define DCCD_STEP_HZ    48'd5000000
`define DCCD_LO2_MIN    48'd6250000000
`define DCCD_LO2_MAX    48'd6450000000
`define DCCD_LO3_MID    48'd1250000000
`define DCCD_LO3_MAX    48'd1750000000
`define DCCD_LO3_MIN    48'd750000000

`endif

/* core/dccd_pkg.sv */
package dccd_pkg;

  typedef enum logic [1:0] {
    DCCD_PORT_PXIE  = 2'b00,
    DCCD_PORT_USB   = 2'b01,
    DCCD_PORT_RS232 = 2'b10,
    DCCD_PORT_SPI   = 2'b11
  } dccd_port_e;

  typedef enum logic [0:0] {
    DCCD_ST_ADDR = 1'b0,
    DCCD_ST_DATA = 1'b1
  } dccd_state_e;

  typedef logic [47:0] dccd_freq_t;

endpackage

/* core/dccd_decoder.sv */
`include "dccd_consts.svh"

module dccd_decoder (
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  input  wire logic                 rx_valid,
  input  wire logic [7:0]           rx_data,
  input  wire dccd_pkg::dccd_port_e rx_port,
  input  wire logic                 ref_detect,
  output logic                      ack_valid,
  output logic [7:0]                ack_data,
  output logic                      reprogram_pulse,
  output logic                      save_pulse,
  output logic                      calibrate_pulse,
  output logic                      atten_pulse,
  output logic                      nvm_pulse,
  output logic                      led_on,
  output logic [1:0]                loop_gain,
  output logic                      fast_tune,
  output dccd_pkg::dccd_freq_t      rf_word,
  output dccd_pkg::dccd_freq_t      if3_word,
  output logic                      preamp_on,
  output logic [7:0]                atten_value,
  output logic [2:0]                atten_target,
  output logic [8:0]                chain_route,
  output logic [31:0]               gain_auto_cfg,
  output logic                      standby_on,
  output logic [2:0]                standby_section,
  output logic [13:0]               base_dac_word,
  output logic                      base_osc_power,
  output logic                      base_lock_ext,
  output logic                      sec_lock_ext,
  output logic                      ref_out_on,
  output logic                      ref_out_100m,
  output logic                      pxi10_on,
  output logic                      lo1_external,
  output logic [7:0]                nvm_data,
  output logic [15:0]               nvm_addr,
  output dccd_pkg::dccd_freq_t      first_local_osc,
  output dccd_pkg::dccd_freq_t      second_local_osc,
  output dccd_pkg::dccd_freq_t      third_local_osc
);
  import dccd_pkg::*;

  typedef struct packed {
    logic        led_on;
    logic [1:0]  loop_gain;
    logic        fast_tune;
    dccd_freq_t  rf_word;
    dccd_freq_t  lo1_word;
    dccd_freq_t  if1_word;
    dccd_freq_t  if2_word;
    dccd_freq_t  if3_word;
    logic        preamp_on;
    logic [7:0]  atten_value;
    logic [2:0]  atten_target;
    logic [8:0]  route;
    logic [31:0] gain_auto;
    logic        standby_on;
    logic [2:0]  standby_sec;
    logic        lock_ext_en;
    logic        ref_out_on;
    logic        ref_100m;
    logic        pxi10_on;
    logic [13:0] dac_word;
    logic        lo1_ext;
  } dccd_cfg_s;

  typedef struct packed {
    dccd_state_e state;
    logic [7:0]  addr;
    logic [2:0]  count;
    logic [2:0]  need;
    logic [55:0] data;
    dccd_cfg_s   cfg;
    logic        ref_s1;
    logic        ref_s2;
    logic        ack_v;
    logic        reprog_p;
    logic        save_p;
    logic        cal_p;
    logic        atten_p;
    logic        nvm_p;
    logic [7:0]  nvm_data;
    logic [15:0] nvm_addr;
    dccd_freq_t  lo1;
    dccd_freq_t  lo2;
    dccd_freq_t  lo3;
  } dccd_state_s;

  dccd_state_s s_q;
  dccd_state_s s_d;

  // Data byte count per address; zero marks an address with no known frame
  function automatic logic [2:0] data_len(input logic [7:0] a);
    case (a)
      `DCCD_A_INWORD:  data_len = 3'd7;
      `DCCD_A_OUTWORD: data_len = 3'd7;
      `DCCD_A_PLAN:    data_len = 3'd7;
      `DCCD_A_AUTOG:   data_len = 3'd5;
      `DCCD_A_ATTEN:   data_len = 3'd3;
      `DCCD_A_ROUTE:   data_len = 3'd3;
      `DCCD_A_TBTRIM:  data_len = 3'd3;
      `DCCD_A_NVM:     data_len = 3'd3;
      `DCCD_A_RELOAD:  data_len = 3'd1;
      `DCCD_A_ACTIVE:  data_len = 3'd1;
      `DCCD_A_SYNTH:   data_len = 3'd1;
      `DCCD_A_PREAMP:  data_len = 3'd1;
      `DCCD_A_SAVE:    data_len = 3'd1;
      `DCCD_A_PWRDN:   data_len = 3'd1;
      `DCCD_A_TBSEL:   data_len = 3'd1;
      `DCCD_A_LO1RT:   data_len = 3'd1;
      `DCCD_A_CAL:     data_len = 3'd1;
      default:         data_len = 3'd0;
    endcase
  endfunction

  function automatic dccd_cfg_s cfg_default();
    dccd_cfg_s c;
    c = '0;
    c.loop_gain = `DCCD_LOOPG_RST;
    c.if1_word  = `DCCD_IF1_RST;
    c.if2_word  = `DCCD_IF2_RST;
    c.if3_word  = `DCCD_IF3_RST;
    return c;
  endfunction

  // Snap to the 5 MHz grid and keep within the oscillator's range
  function automatic dccd_freq_t snap_clamp(input dccd_freq_t f,
                                            input dccd_freq_t lo,
                                            input dccd_freq_t hi);
    dccd_freq_t g;
    g = (f / `DCCD_STEP_HZ) * `DCCD_STEP_HZ;
    if (g < lo) begin
      snap_clamp = lo;
    end else if (g > hi) begin
      snap_clamp = hi;
    end else begin
      snap_clamp = g;
    end
  endfunction

  // Only the ports with a readback step expect the acknowledge byte
  function automatic logic wants_ack(input dccd_port_e p);
    wants_ack = (p == DCCD_PORT_PXIE) || (p == DCCD_PORT_RS232);
  endfunction

  always_comb begin
    logic [55:0] w;
    logic        last;
    dccd_freq_t  lo3_raw;
    w       = '0;
    last    = 1'b0;
    lo3_raw = '0;
    s_d     = s_q;
    // Pulses last one cycle unless set again below
    s_d.ack_v    = 1'b0;
    s_d.reprog_p = 1'b0;
    s_d.save_p   = 1'b0;
    s_d.cal_p    = 1'b0;
    s_d.atten_p  = 1'b0;
    s_d.nvm_p    = 1'b0;
    // Reference detect is asynchronous; only the second stage is read
    s_d.ref_s1   = ref_detect;
    s_d.ref_s2   = s_q.ref_s1;

    // No frame timeout: a wrong byte count shifts every later frame
    // [RULE_01] One byte per step
    if (rx_valid) begin
      // [RULE_04] Port-blind decode
      case (s_q.state)
        DCCD_ST_ADDR: begin
          // [RULE_23] Length from address
          s_d.addr  = rx_data;
          s_d.need  = data_len(rx_data);
          s_d.count = 3'd0;
          s_d.data  = '0;
          if (data_len(rx_data) != 3'd0) begin
            s_d.state = DCCD_ST_DATA;
          end
        end
        DCCD_ST_DATA: begin
          // [RULE_21] Low byte first
          w = s_q.data;
          w[{s_q.count, 3'b000} +: 8] = rx_data;
          s_d.data  = w;
          s_d.count = s_q.count + 3'd1;
          // [RULE_02] Frame ends at count
          last = (s_q.count + 3'd1) == s_q.need;
          if (last) begin
            s_d.state = DCCD_ST_ADDR;
          end
        end
        default: s_d.state = DCCD_ST_ADDR;
      endcase
    end

    // [RULE_09] Apply on each write
    if (last) begin
      // [RULE_07] Readback byte
      s_d.ack_v = wants_ack(rx_port);
      // [RULE_22] Unused bits dropped
      // [RULE_05] Writes set state
      case (s_q.addr)
        `DCCD_A_RELOAD: begin
          // [RULE_08] Reload or restore
          if (w[0]) begin
            s_d.cfg = cfg_default();
          end
          s_d.reprog_p = 1'b1;
        end
        `DCCD_A_ACTIVE: s_d.cfg.led_on = w[0];
        `DCCD_A_SYNTH: begin
          s_d.cfg.loop_gain = w[1:0];
          s_d.cfg.fast_tune = w[2];
        end
        `DCCD_A_INWORD: begin
          // [RULE_06] Flag routes word
          if (w[48]) begin
            s_d.cfg.lo1_word = w[47:0];
          end else begin
            s_d.cfg.rf_word = w[47:0];
          end
        end
        `DCCD_A_OUTWORD: s_d.cfg.if3_word = w[47:0];
        `DCCD_A_PREAMP: s_d.cfg.preamp_on = w[0];
        `DCCD_A_ATTEN: begin
          s_d.cfg.atten_value  = w[7:0];
          s_d.cfg.atten_target = w[10:8];
          s_d.atten_p          = 1'b1;
        end
        `DCCD_A_ROUTE: begin
          s_d.cfg.route     = w[8:0];
          s_d.cfg.preamp_on = w[9];
        end
        `DCCD_A_AUTOG: s_d.cfg.gain_auto = w[31:0];
        `DCCD_A_SAVE: s_d.save_p = 1'b1;
        `DCCD_A_PWRDN: begin
          s_d.cfg.standby_on  = w[0];
          s_d.cfg.standby_sec = w[3:1];
        end
        `DCCD_A_TBSEL: begin
          s_d.cfg.lock_ext_en = w[0];
          s_d.cfg.ref_out_on  = w[1];
          s_d.cfg.ref_100m    = w[2];
          s_d.cfg.pxi10_on    = w[3];
        end
        // [RULE_15] 14-bit trim
        `DCCD_A_TBTRIM: s_d.cfg.dac_word = w[13:0];
        `DCCD_A_LO1RT: s_d.cfg.lo1_ext = w[0];
        `DCCD_A_CAL: s_d.cal_p = 1'b1;
        `DCCD_A_NVM: begin
          s_d.nvm_data = w[7:0];
          s_d.nvm_addr = w[23:8];
          s_d.nvm_p    = 1'b1;
        end
        `DCCD_A_PLAN: begin
          // [RULE_20] Selector picks target
          case (w[51:48])
            `DCCD_SEL_IF1: s_d.cfg.if1_word = w[47:0];
            `DCCD_SEL_IF2: s_d.cfg.if2_word = w[47:0];
            default: s_d.cfg.if1_word = s_q.cfg.if1_word;
          endcase
        end
        default: s_d.cfg = s_q.cfg;
      endcase
    end

    // Oscillators follow settings one cycle later; frequency math is registered
    // [RULE_16] Internal: input plus IF1
    // [RULE_17] External: direct word
    if (s_q.cfg.lo1_ext) begin
      s_d.lo1 = s_q.cfg.lo1_word;
    end else begin
      s_d.lo1 = s_q.cfg.rf_word + s_q.cfg.if1_word;
    end
    // IF2 above IF1 wraps to a huge word, which the clamp pins to the top
    // [RULE_18] IF1 minus IF2
    s_d.lo2 = snap_clamp(s_q.cfg.if1_word - s_q.cfg.if2_word,
                         `DCCD_LO2_MIN, `DCCD_LO2_MAX);
    // [RULE_19] Inversion picks side
    if (s_q.cfg.route[8]) begin
      lo3_raw = s_q.cfg.if2_word - s_q.cfg.if3_word;
      s_d.lo3 = snap_clamp(lo3_raw, `DCCD_LO3_MIN, `DCCD_LO3_MID);
    end else begin
      lo3_raw = s_q.cfg.if2_word + s_q.cfg.if3_word;
      s_d.lo3 = snap_clamp(lo3_raw, `DCCD_LO3_MID, `DCCD_LO3_MAX);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Constants only, so the reset value never depends on live logic
      s_q                  <= '0;
      s_q.cfg.loop_gain    <= `DCCD_LOOPG_RST;
      s_q.cfg.if1_word     <= `DCCD_IF1_RST;
      s_q.cfg.if2_word     <= `DCCD_IF2_RST;
      s_q.cfg.if3_word     <= `DCCD_IF3_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign ack_valid       = s_q.ack_v;
  assign ack_data        = `DCCD_ACK_BYTE;
  assign reprogram_pulse = s_q.reprog_p;
  assign save_pulse      = s_q.save_p;
  assign calibrate_pulse = s_q.cal_p;
  assign atten_pulse     = s_q.atten_p;
  assign nvm_pulse       = s_q.nvm_p;
  assign led_on          = s_q.cfg.led_on;
  assign loop_gain       = s_q.cfg.loop_gain;
  assign fast_tune       = s_q.cfg.fast_tune;
  assign rf_word         = s_q.cfg.rf_word;
  assign if3_word        = s_q.cfg.if3_word;
  assign preamp_on       = s_q.cfg.preamp_on;
  assign atten_value     = s_q.cfg.atten_value;
  assign atten_target    = s_q.cfg.atten_target;
  assign chain_route     = s_q.cfg.route;
  assign gain_auto_cfg   = s_q.cfg.gain_auto;
  assign standby_on      = s_q.cfg.standby_on;
  assign standby_section = s_q.cfg.standby_sec;
  assign base_dac_word   = s_q.cfg.dac_word;
  // [RULE_13] Kept powered for thermal stability
  assign base_osc_power  = 1'b1;
  // [RULE_10] Wait for detection
  // [RULE_12] Both lock external
  assign base_lock_ext   = s_q.cfg.lock_ext_en & s_q.ref_s2;
  // [RULE_11] Else follow base
  assign sec_lock_ext    = s_q.cfg.lock_ext_en & s_q.ref_s2;
  // [RULE_14] Output enable, rate
  assign ref_out_on      = s_q.cfg.ref_out_on;
  assign ref_out_100m    = s_q.cfg.ref_100m;
  assign pxi10_on        = s_q.cfg.pxi10_on;
  assign lo1_external    = s_q.cfg.lo1_ext;
  assign nvm_data        = s_q.nvm_data;
  assign nvm_addr        = s_q.nvm_addr;
  assign first_local_osc  = s_q.lo1;
  assign second_local_osc = s_q.lo2;
  assign third_local_osc  = s_q.lo3;

endmodule // dccd_decoder

/* verif/dccd_props.sv */
`include "dccd_consts.svh"

module dccd_props (
  input wire logic                 core_clk,
  input wire logic                 reset_n,
  input wire logic                 rx_valid,
  input wire dccd_pkg::dccd_port_e rx_port,
  input wire logic                 ref_detect,
  input wire logic                 ack_valid,
  input wire logic [7:0]           ack_data,
  input wire logic                 reprogram_pulse,
  input wire logic                 base_osc_power,
  input wire logic                 base_lock_ext,
  input wire logic                 sec_lock_ext,
  input wire dccd_pkg::dccd_freq_t second_local_osc,
  input wire dccd_pkg::dccd_freq_t third_local_osc
);
  timeunit 1ns;
  timeprecision 1ps;
  import dccd_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  chk_ack_port: assert property (ack_valid |-> $past(rx_valid) &&
    ($past(rx_port) == DCCD_PORT_PXIE || $past(rx_port) == DCCD_PORT_RS232)) else $error("ack on wrong port");
  chk_ack_single: assert property (ack_valid |=> !ack_valid) else $error("ack too long");
  chk_ack_zero: assert property (ack_valid |-> ack_data == `DCCD_ACK_BYTE) else $error("ack byte");
  chk_reload_after: assert property (reprogram_pulse |-> $past(rx_valid)) else $error("reload early");
  chk_osc_power: assert property (base_osc_power) else $error("base osc off");
  chk_lock_pair: assert property (base_lock_ext == sec_lock_ext) else $error("lock split");
  chk_lock_wait: assert property ((!ref_detect)[*4] |-> !base_lock_ext) else $error("lock no ref");
  chk_lo2_range: assert property ($past(reset_n) |-> second_local_osc >= `DCCD_LO2_MIN &&
    second_local_osc <= `DCCD_LO2_MAX && second_local_osc % `DCCD_STEP_HZ == 48'd0) else $error("lo2 range");
  chk_lo3_range: assert property ($past(reset_n) |-> third_local_osc >= `DCCD_LO3_MIN &&
    third_local_osc <= `DCCD_LO3_MAX) else $error("lo3 range");
  cov_ack: cover property (ack_valid);
  cov_lock: cover property ($rose(base_lock_ext));
  cov_reload: cover property (reprogram_pulse);
endmodule // dccd_props

bind dccd_decoder dccd_props u_props (
  .core_clk(core_clk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_port(rx_port), .ref_detect(ref_detect),
  .ack_valid(ack_valid), .ack_data(ack_data), .reprogram_pulse(reprogram_pulse),
  .base_osc_power(base_osc_power), .base_lock_ext(base_lock_ext), .sec_lock_ext(sec_lock_ext),
  .second_local_osc(second_local_osc), .third_local_osc(third_local_osc));

/* verif/dccd_host_model.sv */
module dccd_host_model (
  input wire logic            core_clk,
  output logic                rx_valid,
  output logic [7:0]          rx_data,
  output dccd_pkg::dccd_port_e rx_port
);
  timeunit 1ns;
  timeprecision 1ps;
  import dccd_pkg::*;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_port  = DCCD_PORT_SPI;
  end
  task automatic send(input logic [7:0] addr, input logic [55:0] data, input int n, input dccd_port_e port);
    @(negedge core_clk);
    rx_valid = 1'b1;
    rx_data  = addr;
    rx_port  = port;
    for (int k = 0; k < n; k++) begin
      @(negedge core_clk);
      rx_data = data[8*k +: 8];
    end
    @(negedge core_clk);
    rx_valid = 1'b0;
    // Idle data flips so a stale byte is never mistaken for a fresh one
    rx_data  = ~rx_data;
  endtask
endmodule // dccd_host_model

/* verif/dccd_decoder_tb_top.sv */
module dccd_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dccd_pkg::*;
  logic        core_clk, reset_n, rx_valid, ref_detect;
  logic [7:0]  rx_data, ack_data;
  dccd_port_e  rx_port;
  logic        ack_valid, reprogram_pulse, preamp_on, base_lock_ext, sec_lock_ext, ref_out_on, ref_out_100m;
  logic        lo1_external;
  logic        led_on, fast_tune, save_pulse, calibrate_pulse, atten_pulse, nvm_pulse, standby_on, pxi10_on;
  logic [7:0]  atten_value, nvm_data;
  logic [2:0]  atten_target, standby_section;
  logic [31:0] gain_auto_cfg;
  logic [15:0] nvm_addr;
  logic [1:0]  loop_gain;
  logic [8:0]  chain_route;
  logic [13:0] base_dac_word;
  dccd_freq_t  rf_word, if3_word, first_local_osc, second_local_osc, third_local_osc;
  int          mismatches = 0;
  int          num_checks = 0;

  dccd_host_model u_host (.core_clk(core_clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_port(rx_port));
  dccd_decoder u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_data(rx_data), .rx_port(rx_port),
    .ref_detect(ref_detect), .ack_valid(ack_valid), .ack_data(ack_data), .reprogram_pulse(reprogram_pulse),
    .save_pulse(save_pulse), .calibrate_pulse(calibrate_pulse), .atten_pulse(atten_pulse),
    .nvm_pulse(nvm_pulse), .led_on(led_on), .loop_gain(loop_gain),
    .fast_tune(fast_tune), .rf_word(rf_word), .if3_word(if3_word), .preamp_on(preamp_on),
    .atten_value(atten_value), .atten_target(atten_target), .chain_route(chain_route),
    .gain_auto_cfg(gain_auto_cfg), .standby_on(standby_on), .standby_section(standby_section),
    .base_dac_word(base_dac_word), .base_osc_power(), .base_lock_ext(base_lock_ext),
    .sec_lock_ext(sec_lock_ext), .ref_out_on(ref_out_on), .ref_out_100m(ref_out_100m), .pxi10_on(pxi10_on),
    .lo1_external(lo1_external), .nvm_data(nvm_data), .nvm_addr(nvm_addr), .first_local_osc(first_local_osc),
    .second_local_osc(second_local_osc), .third_local_osc(third_local_osc));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [55:0] d, input int n);
    u_host.send(a, d, n, DCCD_PORT_SPI);
    // Oscillator words follow their inputs one cycle later
    @(negedge core_clk);
  endtask

  task automatic t_reset();
    chk("loop_gain", 2'h1, loop_gain);
    chk("lo1", 48'd7500000000, first_local_osc);
    chk("lo2", 48'd6250000000, second_local_osc);
    chk("lo3", 48'd1250000000, third_local_osc);
  endtask

  task automatic t_ports();
    u_host.send(8'h05, 56'h0, 0, DCCD_PORT_PXIE);
    chk("ack_unknown", 1'b0, ack_valid);
    for (int p = 0; p < 4; p++) begin
      u_host.send(8'h14, (p % 2) ? 56'hfe : 56'h01, 1, dccd_port_e'(p));
      chk("ack_valid", (p == 0 || p == 2), ack_valid);
      chk("preamp_on", (p % 2) == 0, preamp_on);
    end
  endtask

  task automatic t_tune();
    w(8'h10, 56'h0000003b9aca07, 7);
    chk("rf_word", 48'h00003b9aca07, rf_word);
    chk("lo1_int", 48'd8500000007, first_local_osc);
    w(8'h10, {8'h01, 48'd9000000000}, 7);
    chk("rf_keep", 48'h00003b9aca07, rf_word);
    w(8'h1c, 56'h01, 1);
    chk("lo1_external", 1'b1, lo1_external);
    chk("lo1_ext", 48'd9000000000, first_local_osc);
    w(8'h1c, 56'h00, 1);
    chk("lo1_back", 48'd8500000007, first_local_osc);
  endtask

  task automatic t_plan();
    w(8'h1f, {8'h01, 48'd1300000000}, 7);
    chk("lo2_clamp", 48'd6250000000, second_local_osc);
    chk("lo3_if2", 48'd1300000000, third_local_osc);
    w(8'h1f, {8'hf0, 48'd7603500000}, 7);
    chk("lo2_step", 48'd6300000000, second_local_osc);
    w(8'h11, 56'd200000000, 7);
    chk("if3_word", 48'd200000000, if3_word);
    chk("lo3_up", 48'd1500000000, third_local_osc);
    w(8'h16, 56'h000100, 3);
    chk("chain_route", 9'h100, chain_route);
    chk("lo3_down", 48'd1100000000, third_local_osc);
  endtask

  task automatic t_reload();
    w(8'h03, 56'h06, 1);
    chk("loop_gain_w", 2'h2, loop_gain);
    chk("fast_tune", 1'b1, fast_tune);
    u_host.send(8'h01, 56'h00, 1, DCCD_PORT_USB);
    chk("reload0", 1'b1, reprogram_pulse);
    chk("keep_gain", 2'h2, loop_gain);
    u_host.send(8'h01, 56'h01, 1, DCCD_PORT_USB);
    chk("reload1", 1'b1, reprogram_pulse);
    @(negedge core_clk);
    chk("dflt_gain", 2'h1, loop_gain);
    chk("dflt_rf", 48'h0, rf_word);
    chk("dflt_lo2", 48'd6250000000, second_local_osc);
  endtask

  task automatic t_ref();
    w(8'h1a, 56'h07, 1);
    chk("ref_out_on", 1'b1, ref_out_on);
    chk("ref_out_100m", 1'b1, ref_out_100m);
    repeat (5) @(negedge core_clk);
    chk("lock_noref", 1'b0, base_lock_ext);
    ref_detect = 1'b1;
    repeat (4) @(negedge core_clk);
    chk("base_lock", 1'b1, base_lock_ext);
    chk("sec_lock", 1'b1, sec_lock_ext);
    w(8'h1a, 56'h00, 1);
    chk("lock_off", 1'b0, base_lock_ext);
    ref_detect = 1'b0;
  endtask

  // Pulses are looked at in the one cycle they stand
  task automatic t_misc();
    u_host.send(8'h02, 56'h01, 1, DCCD_PORT_SPI);
    chk("led_on", 1'b1, led_on);
    u_host.send(8'h15, 56'h00042a, 3, DCCD_PORT_RS232);
    chk("ack_rs232", 1'b1, ack_valid);
    chk("atten_pulse", 1'b1, atten_pulse);
    chk("atten_value", 8'h2a, atten_value);
    chk("atten_target", 3'h4, atten_target);
    u_host.send(8'h17, 56'h8c968a19, 5, DCCD_PORT_SPI);
    chk("gain_auto_cfg", 32'h8c968a19, gain_auto_cfg);
    u_host.send(8'h18, 56'h00, 1, DCCD_PORT_SPI);
    chk("save_pulse", 1'b1, save_pulse);
    u_host.send(8'h19, 56'h07, 1, DCCD_PORT_SPI);
    chk("standby_on", 1'b1, standby_on);
    chk("standby_section", 3'h3, standby_section);
    u_host.send(8'h1d, 56'h00, 1, DCCD_PORT_SPI);
    chk("calibrate_pulse", 1'b1, calibrate_pulse);
    u_host.send(8'h1e, 56'h12345a, 3, DCCD_PORT_SPI);
    chk("nvm_pulse", 1'b1, nvm_pulse);
    chk("nvm_data", 8'h5a, nvm_data);
    chk("nvm_addr", 16'h1234, nvm_addr);
    @(negedge core_clk);
    chk("nvm_pulse_end", 1'b0, nvm_pulse);
    u_host.send(8'h1a, 56'h08, 1, DCCD_PORT_SPI);
    chk("pxi10_on", 1'b1, pxi10_on);
    chk("ref_out_off", 1'b0, ref_out_on);
  endtask

  task automatic t_dac();
    w(8'h1b, 56'h00ffff, 3);
    chk("dac_mask", 14'h3fff, base_dac_word);
    w(8'h1b, 56'h001234, 3);
    chk("dac_rewrite", 14'h1234, base_dac_word);
  endtask

  task automatic final_report();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    ref_detect = 1'b0;
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    t_reset();
    t_ports();
    t_tune();
    t_plan();
    t_reload();
    t_ref();
    t_misc();
    t_dac();
    final_report();
  end

  // Whole run is about 160 cycles; this limit leaves wide margin
  initial begin
    #100us;
    mismatches++;
    final_report();
  end
endmodule // dccd_decoder_tb_top
